// *** design/irq_fabric_pkg.sv ***
// Shared constants and state type for the external interrupt fabric
package irq_fabric_pkg;

    // Register addresses (SFR space below 0x100, external space above)
    localparam logic [15:0] ADDR_TIMER_CTL   = 16'h0088;
    localparam logic [15:0] ADDR_SER1_EN     = 16'h009A;
    localparam logic [15:0] ADDR_FIRST_EN    = 16'h00A8;
    localparam logic [15:0] ADDR_EXT_EN      = 16'h00B8;
    localparam logic [15:0] ADDR_EXT_REQ     = 16'h00C0;
    localparam logic [15:0] ADDR_EXT_POL     = 16'h00C8;
    localparam logic [15:0] ADDR_SUB_FLAG    = 16'h00E8;
    localparam logic [15:0] ADDR_XFER_TICK   = 16'h2002;
    localparam logic [15:0] ADDR_COL_PLL     = 16'h2007;
    localparam logic [15:0] ADDR_WD_SER_EN   = 16'h20B0;
    localparam logic [15:0] ADDR_WD_SER_FLAG = 16'h20B1;

    // Implemented bits per register; the rest read as zero
    localparam logic [7:0] MASK_TIMER_CTL = 8'hFF;
    localparam logic [7:0] MASK_SER1_EN   = 8'h01;
    localparam logic [7:0] MASK_FIRST_EN  = 8'hDF;
    localparam logic [7:0] MASK_EXT_EN    = 8'h3E;
    localparam logic [7:0] MASK_EXT_REQ   = 8'h3E;
    localparam logic [7:0] MASK_EXT_POL   = 8'h60;
    localparam logic [7:0] MASK_XFER_TICK = 8'h03;
    localparam logic [7:0] MASK_COL_PLL   = 8'h30;
    localparam logic [7:0] MASK_WD_SER    = 8'h11;

    // Reset value shared by every register
    localparam logic [7:0] RESET_REG = 8'h00;

    // First enable register fields
    localparam int FE_GLOBAL = 7;
    localparam int FE_SER0   = 4;
    localparam int FE_TIMER1 = 3;
    localparam int FE_EXT1   = 2;
    localparam int FE_TIMER0 = 1;
    localparam int FE_EXT0   = 0;

    // Timer / external control fields
    localparam int TC_T1_OVF  = 7;
    localparam int TC_T0_OVF  = 5;
    localparam int TC_EXT1_FL = 3;
    localparam int TC_EXT1_TY = 2;
    localparam int TC_EXT0_FL = 1;
    localparam int TC_EXT0_TY = 0;

    // Polarity fields, serial 1 enable
    localparam int POL_EXT3 = 6;
    localparam int POL_EXT2 = 5;
    localparam int SER1_EN  = 0;

    // Shared sub-source flag positions
    localparam int SF_XFER = 0;
    localparam int SF_TICK = 1;
    localparam int SF_COL1 = 2;
    localparam int SF_COL0 = 3;
    localparam int SF_PB   = 4;
    localparam int SF_WAKE = 5;
    localparam int SF_PLLR = 6;
    localparam int SF_PLLF = 7;

    // Sub-source enable positions
    localparam int EN_XFER = 0;
    localparam int EN_TICK = 1;
    localparam int EN_COL  = 4;
    localparam int EN_PLL  = 5;
    localparam int WS_WDOG = 0;
    localparam int WS_SPI  = 4;

    // Whole state of the fabric
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] pin_d;
        logic [7:0] first_en;
        logic [7:0] ser1_en;
        logic [7:0] timer_ctl;
        logic [7:0] ext_en;
        logic [7:0] ext_req;
        logic [7:0] ext_pol;
        logic [7:0] sub_flag;
        logic [7:0] xfer_tick_en;
        logic [7:0] col_pll_en;
        logic [7:0] wd_ser_en;
        logic [7:0] wd_ser_flag;
        logic       grp2_d;
        logic       ce_d;
        logic       grp4_d;
        logic       ee_d;
        logic       grp6_d;
        logic       xfer_d;
        logic       pll_d;
        logic       wake_d;
        logic [7:0] rdata;
    } fabric_state_t;

endpackage : irq_fabric_pkg

// *** design/ext_irq_fabric.sv ***
// Interrupt enable, flag and polarity fabric between core and event sources
`timescale 1ns/1ps

// Functional notes
// - Enable register bits 1..5 enable external interrupts 2..6; zero blocks.
// - Second enable register bit 0 gates serial channel 1 interrupt.
// - Type bits 0 and 2: zero low level, one falling edge for ext 0/1.
// - Timer control holds timer1, timer0, ext1, ext0 flags at bits 7,5,3,1.
// - Polarity bits 6 and 5 pick falling or rising edge for ext 3 and 2.
// - Request register bits 1..5 latch ext 2..6 until cleared.
// - Timer overflow flags clear on the core's active-high service acknowledge.
// - Sources route: collision/serial-slave, compute busy, PLL, EEPROM, transfer/tick/watchdog.
// - Interrupt 5 feed and the transfer-busy sub-source are inverted so falling edges take effect.
// - Ext 0/1 flags and ext 2..6 requests clear when the core vectors.
// - Sub-source flags clear only by writing zero, bar the watchdog flag on wake fall; ones leave them alone.
// - Shared flag byte: transfer, tick, collision1, collision0, button, wake, PLL rise/fall.
// - Transfer and tick enables bits 0,1; collision bit 4, PLL bit 5.
// - Watchdog enable/flag bit 0, serial-slave bit 4, of paired bytes.
// - Sub-source needs its own enable and the group enable to interrupt.
// - Wake and button flags set on wake cause; button also sets while awake.
// - Watchdog near-overflow flag sets early, clears on zero write or wake fall.
// - A compute-engine clash with a flash write raises a collision event.
// - Ext 0/1 are fed from high and low priority digital I/O maps.
// - Global enable bit 7 of the first enable register blocks every interrupt.
module ext_irq_fabric (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        dio_high_prio_in,
    input  wire logic        dio_low_prio_in,
    input  wire logic        push_button,
    input  wire logic        timed_wakeup,
    input  wire logic        wake,
    input  wire logic        flash_collision_zero,
    input  wire logic        flash_collision_one,
    input  wire logic        serial_slave_event,
    input  wire logic        ce_busy,
    input  wire logic        pll_lock,
    input  wire logic        eeprom_busy,
    input  wire logic        transfer_busy,
    input  wire logic        one_second_tick,
    input  wire logic        watchdog_near_overflow,
    input  wire logic        timer0_overflow,
    input  wire logic        timer1_overflow,
    input  wire logic        serial0_request,
    input  wire logic        serial1_request,
    input  wire logic        timer0_service_ack,
    input  wire logic        timer1_service_ack,
    input  wire logic [6:0]  ext_vector_ack,
    output logic      [6:0]  ext_irq,
    output logic             timer0_irq,
    output logic             timer1_irq,
    output logic             serial0_irq,
    output logic             serial1_irq
);

    irq_fabric_pkg::fabric_state_t st_r;
    irq_fabric_pkg::fabric_state_t st_nxt;

    logic       grp2;
    logic       grp4;
    logic       grp6;
    logic       ext2_set;
    logic       ext3_set;
    logic       ext4_set;
    logic       ext5_set;
    logic       ext6_set;
    logic       ext0_set;
    logic       ext1_set;
    logic [7:0] sub_set;
    logic [7:0] wd_set;
    logic       gie;

    // Edge of a level, direction chosen by rising
    function automatic logic edge_of(input logic cur, input logic prev, input logic rising);
        edge_of = rising ? (cur & ~prev) : (~cur & prev);
    endfunction : edge_of

    // Write-zero-to-clear; written ones and hardware sets never clear
    function automatic logic [7:0] zero_clear(input logic [7:0] flags, input logic wr,
                                              input logic [7:0] wdata, input logic [7:0] set);
        zero_clear = (wr ? (flags & wdata) : flags) | set;
    endfunction : zero_clear

    // Plain masked register write
    function automatic logic [7:0] masked_wr(input logic [7:0] old, input logic wr,
                                             input logic [7:0] wdata, input logic [7:0] mask);
        masked_wr = wr ? (wdata & mask) : old;
    endfunction : masked_wr

    // Register read decode, unmapped addresses read zero
    function automatic logic [7:0] read_mux(input irq_fabric_pkg::fabric_state_t s,
                                            input logic [15:0] a);
        case (a)
            irq_fabric_pkg::ADDR_TIMER_CTL:   read_mux = s.timer_ctl;
            irq_fabric_pkg::ADDR_SER1_EN:     read_mux = s.ser1_en;
            irq_fabric_pkg::ADDR_FIRST_EN:    read_mux = s.first_en;
            irq_fabric_pkg::ADDR_EXT_EN:      read_mux = s.ext_en;
            irq_fabric_pkg::ADDR_EXT_REQ:     read_mux = s.ext_req;
            irq_fabric_pkg::ADDR_EXT_POL:     read_mux = s.ext_pol;
            irq_fabric_pkg::ADDR_SUB_FLAG:    read_mux = s.sub_flag;
            irq_fabric_pkg::ADDR_XFER_TICK:   read_mux = s.xfer_tick_en;
            irq_fabric_pkg::ADDR_COL_PLL:     read_mux = s.col_pll_en;
            irq_fabric_pkg::ADDR_WD_SER_EN:   read_mux = s.wd_ser_en;
            irq_fabric_pkg::ADDR_WD_SER_FLAG: read_mux = s.wd_ser_flag;
            default:                          read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // Group requests: enabled sub-flags ORed, then edge detected below
    always_comb
    begin
        grp2 = (st_r.sub_flag[irq_fabric_pkg::SF_COL0]
                & st_r.col_pll_en[irq_fabric_pkg::EN_COL])
             | (st_r.sub_flag[irq_fabric_pkg::SF_COL1]
                & st_r.col_pll_en[irq_fabric_pkg::EN_COL])
             | (st_r.wd_ser_flag[irq_fabric_pkg::WS_SPI]
                & st_r.wd_ser_en[irq_fabric_pkg::WS_SPI]);
        grp4 = (st_r.sub_flag[irq_fabric_pkg::SF_PLLR]
                | st_r.sub_flag[irq_fabric_pkg::SF_PLLF])
             & st_r.col_pll_en[irq_fabric_pkg::EN_PLL];
        grp6 = (st_r.sub_flag[irq_fabric_pkg::SF_XFER]
                & st_r.xfer_tick_en[irq_fabric_pkg::EN_XFER])
             | (st_r.sub_flag[irq_fabric_pkg::SF_TICK]
                & st_r.xfer_tick_en[irq_fabric_pkg::EN_TICK])
             | (st_r.wd_ser_flag[irq_fabric_pkg::WS_WDOG]
                & st_r.wd_ser_en[irq_fabric_pkg::WS_WDOG]);
    end

    // Set events; each flag's set wins over a clear in the same cycle
    always_comb
    begin
        ext2_set = edge_of(grp2, st_r.grp2_d, st_r.ext_pol[irq_fabric_pkg::POL_EXT2]);
        ext3_set = edge_of(ce_busy, st_r.ce_d, st_r.ext_pol[irq_fabric_pkg::POL_EXT3]);
        ext4_set = edge_of(grp4, st_r.grp4_d, 1'b1);
        // Inverted feeds seen rising by the core, i.e. falling edges
        ext5_set = edge_of(~eeprom_busy, ~st_r.ee_d, 1'b1);
        ext6_set = edge_of(grp6, st_r.grp6_d, 1'b1);
        // Low level keeps setting; edge mode catches falling only
        ext0_set = st_r.timer_ctl[irq_fabric_pkg::TC_EXT0_TY]
                 ? edge_of(st_r.sync2[0], st_r.pin_d[0], 1'b0)
                 : ~st_r.sync2[0];
        ext1_set = st_r.timer_ctl[irq_fabric_pkg::TC_EXT1_TY]
                 ? edge_of(st_r.sync2[1], st_r.pin_d[1], 1'b0)
                 : ~st_r.sync2[1];
        sub_set = 8'h00;
        sub_set[irq_fabric_pkg::SF_XFER] = edge_of(~transfer_busy, ~st_r.xfer_d, 1'b1);
        sub_set[irq_fabric_pkg::SF_TICK] = one_second_tick;
        sub_set[irq_fabric_pkg::SF_COL1] = flash_collision_one;
        sub_set[irq_fabric_pkg::SF_COL0] = flash_collision_zero;
        sub_set[irq_fabric_pkg::SF_PB]   = edge_of(st_r.sync2[2], st_r.pin_d[2], 1'b1);
        sub_set[irq_fabric_pkg::SF_WAKE] = timed_wakeup;
        sub_set[irq_fabric_pkg::SF_PLLR] = edge_of(pll_lock, st_r.pll_d, 1'b1);
        sub_set[irq_fabric_pkg::SF_PLLF] = edge_of(pll_lock, st_r.pll_d, 1'b0);
        wd_set = 8'h00;
        wd_set[irq_fabric_pkg::WS_WDOG] = watchdog_near_overflow;
        wd_set[irq_fabric_pkg::WS_SPI]  = serial_slave_event;
    end

    // Next state: synchronisers, registers, flags and edge history
    always_comb
    begin
        logic       wr;
        logic [7:0] tc;
        logic [7:0] rq;
        wr = reg_wr;
        tc = 8'h00;
        rq = 8'h00;
        st_nxt = st_r;
        // Pins pass two stages; only stage two is read by logic
        st_nxt.sync1 = {push_button, dio_low_prio_in, dio_high_prio_in};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.pin_d = st_r.sync2;
        st_nxt.first_en = masked_wr(st_r.first_en, wr && reg_addr == irq_fabric_pkg::ADDR_FIRST_EN,
                                    reg_wdata, irq_fabric_pkg::MASK_FIRST_EN);
        st_nxt.ser1_en = masked_wr(st_r.ser1_en, wr && reg_addr == irq_fabric_pkg::ADDR_SER1_EN,
                                   reg_wdata, irq_fabric_pkg::MASK_SER1_EN);
        st_nxt.ext_en = masked_wr(st_r.ext_en, wr && reg_addr == irq_fabric_pkg::ADDR_EXT_EN,
                                  reg_wdata, irq_fabric_pkg::MASK_EXT_EN);
        st_nxt.ext_pol = masked_wr(st_r.ext_pol, wr && reg_addr == irq_fabric_pkg::ADDR_EXT_POL,
                                   reg_wdata, irq_fabric_pkg::MASK_EXT_POL);
        st_nxt.xfer_tick_en = masked_wr(st_r.xfer_tick_en,
                                        wr && reg_addr == irq_fabric_pkg::ADDR_XFER_TICK,
                                        reg_wdata, irq_fabric_pkg::MASK_XFER_TICK);
        st_nxt.col_pll_en = masked_wr(st_r.col_pll_en,
                                      wr && reg_addr == irq_fabric_pkg::ADDR_COL_PLL,
                                      reg_wdata, irq_fabric_pkg::MASK_COL_PLL);
        st_nxt.wd_ser_en = masked_wr(st_r.wd_ser_en,
                                     wr && reg_addr == irq_fabric_pkg::ADDR_WD_SER_EN,
                                     reg_wdata, irq_fabric_pkg::MASK_WD_SER);
        // Timer control: software write, then acks clear, then sets win
        tc = masked_wr(st_r.timer_ctl, wr && reg_addr == irq_fabric_pkg::ADDR_TIMER_CTL,
                       reg_wdata, irq_fabric_pkg::MASK_TIMER_CTL);
        if (timer0_service_ack)
            tc[irq_fabric_pkg::TC_T0_OVF] = 1'b0;
        if (timer1_service_ack)
            tc[irq_fabric_pkg::TC_T1_OVF] = 1'b0;
        if (ext_vector_ack[0])
            tc[irq_fabric_pkg::TC_EXT0_FL] = 1'b0;
        if (ext_vector_ack[1])
            tc[irq_fabric_pkg::TC_EXT1_FL] = 1'b0;
        tc[irq_fabric_pkg::TC_T0_OVF]  = tc[irq_fabric_pkg::TC_T0_OVF] | timer0_overflow;
        tc[irq_fabric_pkg::TC_T1_OVF]  = tc[irq_fabric_pkg::TC_T1_OVF] | timer1_overflow;
        tc[irq_fabric_pkg::TC_EXT0_FL] = tc[irq_fabric_pkg::TC_EXT0_FL] | ext0_set;
        tc[irq_fabric_pkg::TC_EXT1_FL] = tc[irq_fabric_pkg::TC_EXT1_FL] | ext1_set;
        st_nxt.timer_ctl = tc;
        // Request register: vector acks clear, edge sets win
        rq = masked_wr(st_r.ext_req, wr && reg_addr == irq_fabric_pkg::ADDR_EXT_REQ,
                       reg_wdata, irq_fabric_pkg::MASK_EXT_REQ);
        rq[5:1] = rq[5:1] & ~ext_vector_ack[6:2];
        rq[5:1] = rq[5:1] | {ext6_set, ext5_set, ext4_set, ext3_set, ext2_set};
        st_nxt.ext_req = rq;
        // Sub-source flags ignore written ones
        st_nxt.sub_flag = zero_clear(st_r.sub_flag,
                                     wr && reg_addr == irq_fabric_pkg::ADDR_SUB_FLAG,
                                     reg_wdata, sub_set);
        st_nxt.wd_ser_flag = zero_clear(st_r.wd_ser_flag,
                                        wr && reg_addr == irq_fabric_pkg::ADDR_WD_SER_FLAG,
                                        reg_wdata | ~irq_fabric_pkg::MASK_WD_SER, 8'h00)
                             & irq_fabric_pkg::MASK_WD_SER;
        if (edge_of(wake, st_r.wake_d, 1'b0))
            st_nxt.wd_ser_flag[irq_fabric_pkg::WS_WDOG] = 1'b0;
        st_nxt.wd_ser_flag = st_nxt.wd_ser_flag | wd_set;
        st_nxt.grp2_d = grp2;
        st_nxt.ce_d   = ce_busy;
        st_nxt.grp4_d = grp4;
        st_nxt.ee_d   = eeprom_busy;
        st_nxt.grp6_d = grp6;
        st_nxt.xfer_d = transfer_busy;
        st_nxt.pll_d  = pll_lock;
        st_nxt.wake_d = wake;
        // Read data is captured, so it stays valid after the strobe drops
        if (reg_rd)
            st_nxt.rdata = read_mux(st_r, reg_addr);
    end

    // One register bank for the whole state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Pin stages start at the idle level so no false low or edge follows reset
            st_r       <= '0;
            st_r.sync1 <= 3'h3;
            st_r.sync2 <= 3'h3;
            st_r.pin_d <= 3'h3;
        end
        else
            st_r <= st_nxt;
    end

    // Requests to the core, all gated by the global enable
    always_comb
    begin
        gie = st_r.first_en[irq_fabric_pkg::FE_GLOBAL];
        ext_irq[0]  = gie & st_r.first_en[irq_fabric_pkg::FE_EXT0]
                    & st_r.timer_ctl[irq_fabric_pkg::TC_EXT0_FL];
        ext_irq[1]  = gie & st_r.first_en[irq_fabric_pkg::FE_EXT1]
                    & st_r.timer_ctl[irq_fabric_pkg::TC_EXT1_FL];
        ext_irq[6:2] = {5{gie}} & st_r.ext_en[5:1] & st_r.ext_req[5:1];
        timer0_irq  = gie & st_r.first_en[irq_fabric_pkg::FE_TIMER0]
                    & st_r.timer_ctl[irq_fabric_pkg::TC_T0_OVF];
        timer1_irq  = gie & st_r.first_en[irq_fabric_pkg::FE_TIMER1]
                    & st_r.timer_ctl[irq_fabric_pkg::TC_T1_OVF];
        serial0_irq = gie & st_r.first_en[irq_fabric_pkg::FE_SER0] & serial0_request;
        serial1_irq = gie & st_r.ser1_en[irq_fabric_pkg::SER1_EN] & serial1_request;
    end

    assign reg_rdata = st_r.rdata;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_global_blocks: assert property (!st_r.first_en[7] |-> ext_irq == 7'h00 && !timer0_irq
        && !timer1_irq && !serial1_irq) else $error("interrupt raised with global enable off");
    a_serial1_gate: assert property (!st_r.ser1_en[0] |-> !serial1_irq)
        else $error("serial 1 interrupt while disabled");
    a_timer0_ack: assert property (timer0_service_ack && !timer0_overflow |=> !st_r.timer_ctl[5])
        else $error("timer 0 flag survived acknowledge");
    a_timer1_set: assert property (timer1_overflow |=> st_r.timer_ctl[7])
        else $error("timer 1 overflow not latched");
    a_ext0_fall: assert property (st_r.timer_ctl[0] && $fell(dio_high_prio_in)
        |-> ##3 st_r.timer_ctl[1]) else $error("ext 0 falling edge not latched");
    a_ones_ignored: assert property (reg_wr && reg_addr == 16'h00E8 && reg_wdata == 8'hFF
        |=> (st_r.sub_flag & $past(st_r.sub_flag)) == $past(st_r.sub_flag))
        else $error("writing ones cleared a sub-source flag");
    a_xfer_fall: assert property ($fell(transfer_busy) |=> st_r.sub_flag[0])
        else $error("transfer busy fall not flagged");
    a_eeprom_fall: assert property ($fell(eeprom_busy) |=> st_r.ext_req[4])
        else $error("eeprom busy fall not requested");
    a_wdog_wake: assert property ($fell(wake) && !watchdog_near_overflow |=> !st_r.wd_ser_flag[0])
        else $error("watchdog flag not cleared by wake fall");
    a_group6_edge: assert property (!st_r.grp6_d && grp6 |=> st_r.ext_req[5])
        else $error("group 6 request not latched");
    a_ext3_ack: assert property (ext_vector_ack[3] && !ext3_set |=> !st_r.ext_req[2])
        else $error("ext 3 request survived vector acknowledge");

endmodule : ext_irq_fabric

// *** sim/core_ack_model.sv ***
// Core-side partner that acknowledges interrupts as the core vectors to them
`timescale 1ns/1ps
module core_ack_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       auto_ack,
    input  wire logic [6:0] ext_irq,
    input  wire logic       timer0_irq,
    input  wire logic       timer1_irq,
    output logic      [6:0] ext_vector_ack,
    output logic            timer0_service_ack,
    output logic            timer1_service_ack
);
    // One-cycle acks off the sampling edge; no ack twice in a row
    always @(negedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_vector_ack     <= 7'h00;
            timer0_service_ack <= 1'b0;
            timer1_service_ack <= 1'b0;
        end
        else
        begin
            ext_vector_ack     <= auto_ack ? (ext_irq & ~ext_vector_ack) : 7'h00;
            timer0_service_ack <= auto_ack & timer0_irq & ~timer0_service_ack;
            timer1_service_ack <= auto_ack & timer1_irq & ~timer1_service_ack;
        end
    end
endmodule : core_ack_model

// *** sim/ext_irq_fabric_tb.sv ***
// Self-checking bench for the external interrupt fabric
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module ext_irq_fabric_tb;
    logic        sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, auto_ack = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, rv;
    logic        dio_high_prio_in = 1'b1, dio_low_prio_in = 1'b1, push_button = 1'b0;
    logic        timed_wakeup = 1'b0, wake = 1'b0, flash_collision_zero = 1'b0;
    logic        flash_collision_one = 1'b0, serial_slave_event = 1'b0, ce_busy = 1'b0;
    logic        pll_lock = 1'b0, eeprom_busy = 1'b0, transfer_busy = 1'b0;
    logic        one_second_tick = 1'b0, watchdog_near_overflow = 1'b0;
    logic        timer0_overflow = 1'b0, timer1_overflow = 1'b0;
    logic        serial0_request = 1'b0, serial1_request = 1'b0;
    logic        timer0_service_ack, timer1_service_ack, timer0_irq, timer1_irq;
    logic        serial0_irq, serial1_irq;
    logic [6:0]  ext_vector_ack, ext_irq;
    int          n_fail = 0, compares = 0;
    logic [15:0] ra [11] = '{16'h0088, 16'h009A, 16'h00A8, 16'h00B8, 16'h00C0, 16'h00C8,
                             16'h2002, 16'h2007, 16'h20B0, 16'h00E8, 16'h20B1};
    logic [7:0]  rm [9]  = '{8'hFF, 8'h01, 8'hDF, 8'h3E, 8'h3E, 8'h60, 8'h03, 8'h30, 8'h11};

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    ext_irq_fabric dut (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .dio_high_prio_in, .dio_low_prio_in, .push_button, .timed_wakeup, .wake,
        .flash_collision_zero, .flash_collision_one, .serial_slave_event, .ce_busy, .pll_lock,
        .eeprom_busy, .transfer_busy, .one_second_tick, .watchdog_near_overflow,
        .timer0_overflow, .timer1_overflow, .serial0_request, .serial1_request,
        .timer0_service_ack, .timer1_service_ack, .ext_vector_ack, .ext_irq, .timer0_irq,
        .timer1_irq, .serial0_irq, .serial1_irq);

    core_ack_model core (.sys_clk, .resetn, .auto_ack, .ext_irq, .timer0_irq, .timer1_irq,
        .ext_vector_ack, .timer0_service_ack, .timer1_service_ack);

    // One-cycle write strobe, launched off the sampling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
    endtask : wr

    // Read data lands on the edge after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd

    task automatic end_sim;
        $display("checks %0d failures %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Main sequence
    initial
    begin
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        // Reset values, unmapped read
        foreach (ra[i]) begin rd(ra[i], rv); `CHK(rv, 8'h00) end
        rd(16'h0050, rv); `CHK(rv, 8'h00)
        // Only implemented bits keep ones
        foreach (rm[i]) begin wr(ra[i], 8'hFF); rd(ra[i], rv); `CHK(rv, rm[i]) end
        foreach (rm[i]) wr(ra[i], 8'h00);
        wr(16'h00C8, 8'h00);
        // Tick sub-source through group 6
        wr(16'h2002, 8'h02);
        wr(16'h00B8, 8'h20);
        wr(16'h00A8, 8'h80);
        @(negedge sys_clk) one_second_tick = 1'b1;
        @(negedge sys_clk) one_second_tick = 1'b0;
        @(negedge sys_clk) `CHK(ext_irq[6], 1'b1)
        rd(16'h00C0, rv); `CHK(rv, 8'h20)
        wr(16'h00B8, 8'h00); `CHK(ext_irq[6], 1'b0)
        wr(16'h00B8, 8'h20);
        auto_ack = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(16'h00C0, rv); `CHK(rv, 8'h00)
        rd(16'h00E8, rv); `CHK(rv, 8'h02)
        wr(16'h00E8, 8'hFF); rd(16'h00E8, rv); `CHK(rv, 8'h02)
        wr(16'h00E8, 8'hFD); rd(16'h00E8, rv); `CHK(rv, 8'h00)
        // Timer 0 overflow, global gate, hardware ack
        auto_ack = 1'b0;
        wr(16'h00A8, 8'h02);
        @(negedge sys_clk) timer0_overflow = 1'b1;
        @(negedge sys_clk) timer0_overflow = 1'b0;
        rd(16'h0088, rv); `CHK(rv, 8'h20)
        `CHK(timer0_irq, 1'b0)
        wr(16'h00A8, 8'h82); `CHK(timer0_irq, 1'b1)
        auto_ack = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(16'h0088, rv); `CHK(rv, 8'h00)
        // Serial 1 and serial 0 gates
        serial1_request = 1'b1;
        @(negedge sys_clk) `CHK(serial1_irq, 1'b0)
        wr(16'h009A, 8'h01); `CHK(serial1_irq, 1'b1)
        serial0_request = 1'b1;
        @(negedge sys_clk) `CHK(serial0_irq, 1'b0)
        wr(16'h00A8, 8'h90); `CHK(serial0_irq, 1'b1)
        end_sim();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
endmodule : ext_irq_fabric_tb
